// ### rtl/pxb_pkg.sv
// Constants for the port I/O priority crossbar: pin counts, register offsets,
// field positions, reset values and crossbar slot codes.
// Assumes an 8-bit register port and 21 pins (P0.0..P2.4).
package pxb_pkg;
    // Pin counts
    localparam int NUM_PINS = 21;
    localparam int XBAR_PINS = 20;
    localparam int NUM_SLOTS = 19;
    localparam int NUM_PORTS = 3;
    localparam int UART_TX_PIN = 4;
    localparam int UART_RX_PIN = 5;

    // Register offsets
    localparam logic [7:0] ADDR_SEL_LO = 8'h00;
    localparam logic [7:0] ADDR_SEL_HI = 8'h01;
    localparam logic [7:0] ADDR_IN_MODE = 8'h02;
    localparam logic [7:0] ADDR_OUT_MODE = 8'h05;
    localparam logic [7:0] ADDR_SKIP = 8'h08;
    localparam logic [7:0] ADDR_LATCH = 8'h0B;
    localparam logic [7:0] ADDR_EXT_CFG = 8'h0E;
    localparam logic [7:0] ADDR_P0_MASK = 8'h0F;
    localparam logic [7:0] ADDR_P0_VALUE = 8'h10;
    localparam logic [7:0] ADDR_P1_MASK = 8'h11;
    localparam logic [7:0] ADDR_P1_VALUE = 8'h12;
    localparam logic [7:0] ADDR_EVENT_STAT = 8'h13;

    // Reset values
    localparam logic [7:0] RST_SEL = 8'h00;
    localparam logic [7:0] RST_IN_MODE = 8'hFF;
    localparam logic [7:0] RST_OUT_MODE = 8'h00;
    localparam logic [7:0] RST_SKIP = 8'h00;
    localparam logic [7:0] RST_LATCH = 8'hFF;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] P2_BITS = 8'h1F;

    // Select-low field positions
    localparam int LO_UART_EN = 0;
    localparam int LO_SPI_EN = 1;
    localparam int LO_SMB0_EN = 2;
    localparam int LO_SYSCLK_EN = 3;
    localparam int LO_CMP_SYNC_EN = 4;
    localparam int LO_CMP_ASYNC_EN = 5;
    localparam int LO_SMB1_EN = 6;
    // Select-high field positions
    localparam int HI_CH_LSB = 0;
    localparam int HI_CNT_CLK_EN = 3;
    localparam int HI_TMR_ZERO_EN = 4;
    localparam int HI_TMR_ONE_EN = 5;
    localparam int HI_XBAR_EN = 6;
    localparam int HI_WPU_DIS = 7;

    // Slot indices, in priority order; pin code is slot + 1, 0 means GPIO
    localparam int SLOT_UART_TX = 0;
    localparam int SLOT_UART_RX = 1;
    localparam int SLOT_SPI = 2;
    localparam int SLOT_SMB0 = 6;
    localparam int SLOT_SMB1 = 8;
    localparam int SLOT_CMP_SYNC = 10;
    localparam int SLOT_CMP_ASYNC = 11;
    localparam int SLOT_SYSCLK = 12;
    localparam int SLOT_CH0 = 13;
    localparam int SLOT_CNT_CLK = 16;
    localparam int SLOT_TMR_ZERO = 17;
    localparam int SLOT_TMR_ONE = 18;
endpackage : pxb_pkg

// ### rtl/pxb_port_io_crossbar.sv
// Port I/O cell control and priority crossbar with register port.
// Assumes pad buffers outside resolve pad_out/pad_oe/pad_pullup into the wire.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
module pxb_port_io_crossbar (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [18:0] periph_out,
    input wire logic [18:0] periph_oe,
    output logic [18:0] periph_in,
    input wire logic [20:0] pad_in,
    output logic [20:0] pad_out,
    output logic [20:0] pad_oe,
    output logic [20:0] pad_pullup,
    output logic [1:0] ext_int_level,
    output logic port_match,
    output logic [2:0] event_pulse
);
    ////////////////////////////////////////////////////////////////////////////
    // Address decode helpers
    function automatic logic grp_hit(input logic [7:0] addr, input logic [7:0] base);
        grp_hit = (addr >= base) && (addr < base + 8'h03);
    endfunction : grp_hit

    function automatic logic [1:0] grp_idx(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] diff;
        diff = addr - base;
        grp_idx = diff[1:0];
    endfunction : grp_idx

    function automatic logic slot_is_smbus(input logic [4:0] code);
        slot_is_smbus = (code >= 5'(pxb_pkg::SLOT_SMB0 + 1))
            && (code <= 5'(pxb_pkg::SLOT_SMB1 + 2));
    endfunction : slot_is_smbus

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] sel_lo_reg;
    logic [7:0] sel_hi_reg;
    logic [7:0] in_mode_reg [0:2];
    logic [7:0] out_mode_reg [0:2];
    logic [7:0] skip_reg [0:2];
    logic [7:0] latch_reg [0:2];
    logic [7:0] ext_cfg_reg;
    logic [7:0] p0_mask_reg;
    logic [7:0] p0_value_reg;
    logic [7:0] p1_mask_reg;
    logic [7:0] p1_value_reg;

    // Crossbar select registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_lo_reg <= pxb_pkg::RST_SEL;
            sel_hi_reg <= pxb_pkg::RST_SEL;
        end else if (reg_wr) begin
            if (reg_addr == pxb_pkg::ADDR_SEL_LO) sel_lo_reg <= reg_wdata;
            if (reg_addr == pxb_pkg::ADDR_SEL_HI) sel_hi_reg <= reg_wdata & 8'hFB;
        end
    end

    // Per-port mode, skip and latch registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < pxb_pkg::NUM_PORTS; i++) begin
                in_mode_reg[i] <= pxb_pkg::RST_IN_MODE;
                out_mode_reg[i] <= pxb_pkg::RST_OUT_MODE;
                skip_reg[i] <= pxb_pkg::RST_SKIP;
                latch_reg[i] <= pxb_pkg::RST_LATCH;
            end
        end else if (reg_wr) begin
            if (grp_hit(reg_addr, pxb_pkg::ADDR_IN_MODE))
                in_mode_reg[grp_idx(reg_addr, pxb_pkg::ADDR_IN_MODE)] <= reg_wdata;
            if (grp_hit(reg_addr, pxb_pkg::ADDR_OUT_MODE))
                out_mode_reg[grp_idx(reg_addr, pxb_pkg::ADDR_OUT_MODE)] <= reg_wdata;
            if (grp_hit(reg_addr, pxb_pkg::ADDR_SKIP))
                skip_reg[grp_idx(reg_addr, pxb_pkg::ADDR_SKIP)] <= reg_wdata;
            if (grp_hit(reg_addr, pxb_pkg::ADDR_LATCH))
                latch_reg[grp_idx(reg_addr, pxb_pkg::ADDR_LATCH)] <= reg_wdata;
        end
    end

    // Event trigger configuration registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_cfg_reg <= pxb_pkg::RST_CFG;
            p0_mask_reg <= pxb_pkg::RST_CFG;
            p0_value_reg <= pxb_pkg::RST_CFG;
            p1_mask_reg <= pxb_pkg::RST_CFG;
            p1_value_reg <= pxb_pkg::RST_CFG;
        end else if (reg_wr) begin
            if (reg_addr == pxb_pkg::ADDR_EXT_CFG) ext_cfg_reg <= reg_wdata;
            if (reg_addr == pxb_pkg::ADDR_P0_MASK) p0_mask_reg <= reg_wdata;
            if (reg_addr == pxb_pkg::ADDR_P0_VALUE) p0_value_reg <= reg_wdata;
            if (reg_addr == pxb_pkg::ADDR_P1_MASK) p1_mask_reg <= reg_wdata;
            if (reg_addr == pxb_pkg::ADDR_P1_VALUE) p1_value_reg <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flattened per-pin views
    logic xbar_en;
    logic wpu_dis;
    logic [20:0] dig_mask;
    logic [20:0] pp_mask;
    logic [20:0] latch_all;
    logic [19:0] skip_all;
    logic [20:0] pad_dig;

    assign xbar_en = sel_hi_reg[pxb_pkg::HI_XBAR_EN];
    assign wpu_dis = sel_hi_reg[pxb_pkg::HI_WPU_DIS];
    assign dig_mask = {in_mode_reg[2][4:0], in_mode_reg[1], in_mode_reg[0]};
    assign pp_mask = {out_mode_reg[2][4:0], out_mode_reg[1], out_mode_reg[0]};
    assign latch_all = {latch_reg[2][4:0], latch_reg[1], latch_reg[0]};
    assign skip_all = {skip_reg[2][3:0], skip_reg[1], skip_reg[0]};
    assign pad_dig = pad_in & dig_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Slot enables in priority order
    logic [18:0] slot_en;
    logic [1:0] ch_cnt;

    assign ch_cnt = sel_hi_reg[pxb_pkg::HI_CH_LSB +: 2];
    always_comb begin
        slot_en = '0;
        slot_en[pxb_pkg::SLOT_UART_TX] = sel_lo_reg[pxb_pkg::LO_UART_EN];
        slot_en[pxb_pkg::SLOT_UART_RX] = sel_lo_reg[pxb_pkg::LO_UART_EN];
        slot_en[pxb_pkg::SLOT_SPI +: 4] = {4{sel_lo_reg[pxb_pkg::LO_SPI_EN]}};
        slot_en[pxb_pkg::SLOT_SMB0 +: 2] = {2{sel_lo_reg[pxb_pkg::LO_SMB0_EN]}};
        slot_en[pxb_pkg::SLOT_SMB1 +: 2] = {2{sel_lo_reg[pxb_pkg::LO_SMB1_EN]}};
        slot_en[pxb_pkg::SLOT_CMP_SYNC] = sel_lo_reg[pxb_pkg::LO_CMP_SYNC_EN];
        slot_en[pxb_pkg::SLOT_CMP_ASYNC] = sel_lo_reg[pxb_pkg::LO_CMP_ASYNC_EN];
        slot_en[pxb_pkg::SLOT_SYSCLK] = sel_lo_reg[pxb_pkg::LO_SYSCLK_EN];
        slot_en[pxb_pkg::SLOT_CH0] = (ch_cnt >= 2'h1);
        slot_en[pxb_pkg::SLOT_CH0 + 1] = (ch_cnt >= 2'h2);
        slot_en[pxb_pkg::SLOT_CH0 + 2] = (ch_cnt == 2'h3);
        slot_en[pxb_pkg::SLOT_CNT_CLK] = sel_hi_reg[pxb_pkg::HI_CNT_CLK_EN];
        slot_en[pxb_pkg::SLOT_TMR_ZERO] = sel_hi_reg[pxb_pkg::HI_TMR_ZERO_EN];
        slot_en[pxb_pkg::SLOT_TMR_ONE] = sel_hi_reg[pxb_pkg::HI_TMR_ONE_EN];
        if (!xbar_en) slot_en = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority decoder: code per crossbar pin, 0 leaves the pin as GPIO
    logic [4:0] pin_code [0:19];

    always_comb begin
        logic [19:0] occ;
        logic placed;
        occ = skip_all;
        placed = 1'b0;
        for (int p = 0; p < pxb_pkg::XBAR_PINS; p++) pin_code[p] = 5'h00;
        if (slot_en[pxb_pkg::SLOT_UART_TX]) begin
            pin_code[pxb_pkg::UART_TX_PIN] = 5'(pxb_pkg::SLOT_UART_TX + 1);
            pin_code[pxb_pkg::UART_RX_PIN] = 5'(pxb_pkg::SLOT_UART_RX + 1);
            occ[pxb_pkg::UART_TX_PIN] = 1'b1;
            occ[pxb_pkg::UART_RX_PIN] = 1'b1;
        end
        for (int s = pxb_pkg::SLOT_SPI; s < pxb_pkg::NUM_SLOTS; s++) begin
            placed = 1'b0;
            for (int p = 0; p < pxb_pkg::XBAR_PINS; p++) begin
                if (slot_en[s] && !placed && !occ[p]) begin
                    pin_code[p] = 5'(s + 1);
                    occ[p] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive, pullup and peripheral input selection
    logic [20:0] oe_next;
    logic [20:0] out_next;
    logic [20:0] pu_next;
    logic [18:0] pin_next;
    logic [20:0] smb_pins;

    always_comb begin
        logic val;
        logic want;
        logic od;
        val = 1'b0;
        want = 1'b0;
        od = 1'b0;
        pin_next = '0;
        smb_pins = '0;
        for (int p = 0; p < pxb_pkg::NUM_PINS; p++) begin
            val = latch_all[p];
            want = 1'b1;
            od = !pp_mask[p];
            if (p < pxb_pkg::XBAR_PINS && pin_code[p] != 5'h00) begin
                val = periph_out[pin_code[p] - 5'h01];
                want = periph_oe[pin_code[p] - 5'h01];
                smb_pins[p] = slot_is_smbus(pin_code[p]);
                od = od || smb_pins[p];
                pin_next[pin_code[p] - 5'h01] = pad_dig[p];
            end
            want = want && xbar_en && dig_mask[p];
            oe_next[p] = want && (!od || !val);
            out_next[p] = !od && val;
            pu_next[p] = dig_mask[p] && !wpu_dis && !(oe_next[p] && !out_next[p]);
        end
    end

    // Registered pad controls; reset leaves pads floating with pullups
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pad_oe <= '0;
            pad_out <= '0;
            pad_pullup <= '1;
            periph_in <= '0;
        end else begin
            pad_oe <= oe_next;
            pad_out <= out_next;
            pad_pullup <= pu_next;
            periph_in <= pin_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External interrupts and port match
    logic [2:0] int_sel [0:1];
    logic [1:0] int_next;
    logic match_next;

    assign int_sel[0] = ext_cfg_reg[2:0];
    assign int_sel[1] = ext_cfg_reg[6:4];
    assign int_next[0] = dig_mask[int_sel[0]] && (pad_dig[int_sel[0]] == ext_cfg_reg[3]);
    assign int_next[1] = dig_mask[int_sel[1]] && (pad_dig[int_sel[1]] == ext_cfg_reg[7]);
    assign match_next = |(({p1_value_reg, p0_value_reg} ^ pad_dig[15:0])
        & {p1_mask_reg, p0_mask_reg} & dig_mask[15:0]);

    // Levels and rising-edge event pulses
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_int_level <= '0;
            port_match <= 1'b0;
            event_pulse <= '0;
        end else begin
            ext_int_level <= int_next;
            port_match <= match_next;
            event_pulse <= {match_next, int_next} & ~{port_match, ext_int_level};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port; data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (grp_hit(reg_addr, pxb_pkg::ADDR_LATCH)) begin
            case (grp_idx(reg_addr, pxb_pkg::ADDR_LATCH))
                2'h0: reg_rdata <= pad_dig[7:0];
                2'h1: reg_rdata <= pad_dig[15:8];
                default: reg_rdata <= {3'h0, pad_dig[20:16]};
            endcase
        end else if (grp_hit(reg_addr, pxb_pkg::ADDR_IN_MODE)) begin
            reg_rdata <= in_mode_reg[grp_idx(reg_addr, pxb_pkg::ADDR_IN_MODE)];
        end else if (grp_hit(reg_addr, pxb_pkg::ADDR_OUT_MODE)) begin
            reg_rdata <= out_mode_reg[grp_idx(reg_addr, pxb_pkg::ADDR_OUT_MODE)];
        end else if (grp_hit(reg_addr, pxb_pkg::ADDR_SKIP)) begin
            reg_rdata <= skip_reg[grp_idx(reg_addr, pxb_pkg::ADDR_SKIP)];
        end else begin
            case (reg_addr)
                pxb_pkg::ADDR_SEL_LO: reg_rdata <= sel_lo_reg;
                pxb_pkg::ADDR_SEL_HI: reg_rdata <= sel_hi_reg;
                pxb_pkg::ADDR_EXT_CFG: reg_rdata <= ext_cfg_reg;
                pxb_pkg::ADDR_P0_MASK: reg_rdata <= p0_mask_reg;
                pxb_pkg::ADDR_P0_VALUE: reg_rdata <= p0_value_reg;
                pxb_pkg::ADDR_P1_MASK: reg_rdata <= p1_mask_reg;
                pxb_pkg::ADDR_P1_VALUE: reg_rdata <= p1_value_reg;
                pxb_pkg::ADDR_EVENT_STAT: reg_rdata <= {5'h00, port_match, ext_int_level};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_wpu_dis_write;
        reg_wr && reg_addr == pxb_pkg::ADDR_SEL_HI && reg_wdata[pxb_pkg::HI_WPU_DIS];
    endsequence

    sequence s_latch0_read;
        reg_rd && reg_addr == pxb_pkg::ADDR_LATCH;
    endsequence

    a_reset_float_pullup: assert property ($fell(rst) |-> pad_oe == '0 && pad_pullup == '1)
        else $error("pads not floating with pullups after reset");
    a_xbar_off_drive: assert property (!xbar_en |=> pad_oe[19:0] == '0)
        else $error("driver enabled while crossbar disabled");
    a_analog_cell_off: assert property (1 |=> ((pad_oe | pad_pullup) & ~$past(dig_mask)) == '0)
        else $error("analog pin has driver or pullup");
    a_latch_read_pad: assert property (s_latch0_read |=>
        reg_rdata == ($past(pad_in[7:0]) & $past(dig_mask[7:0])))
        else $error("port read does not match pad and input mode");
    a_open_drain_high: assert property (1 |=> (pad_oe & pad_out & ~$past(pp_mask)) == '0)
        else $error("open-drain pin driven high");
    a_wpu_disable: assert property (s_wpu_dis_write |-> ##2 pad_pullup == '0)
        else $error("pullups still on after global disable");
    a_uart_fixed_pins: assert property (slot_en[pxb_pkg::SLOT_UART_TX] |->
        pin_code[4] == 5'h01 && pin_code[5] == 5'h02)
        else $error("uart not on fixed pins");
    a_skip_not_taken: assert property (!slot_en[0] |-> (skip_all[0] -> pin_code[0] == 5'h00))
        else $error("skipped pin assigned");
    a_lowest_pin_first: assert property ((|slot_en[18:2] && !skip_all[0]) |-> pin_code[0] != 5'h00)
        else $error("lowest free pin left unassigned");
    a_smbus_no_high: assert property (1 |=> (pad_oe & pad_out & $past(smb_pins)) == '0)
        else $error("smbus pin driven high");
    a_gpio_from_latch: assert property ((xbar_en && dig_mask[20] && pp_mask[20]) |=>
        pad_oe[20] && pad_out[20] == $past(latch_all[20]))
        else $error("gpio pin not following latch");
    a_analog_no_int: assert property (!dig_mask[int_sel[0]] |=> !ext_int_level[0])
        else $error("interrupt active on analog pin");
endmodule : pxb_port_io_crossbar

// ### tb/pxb_board_model.sv
// Board circuits on the port pins: resolves each pad wire from all drivers.
// Assumes the bench sets ext_en/ext_val for pins that the board drives.
module pxb_board_model (
    input wire logic clk_sys,
    input wire logic [20:0] pad_out,
    input wire logic [20:0] pad_oe,
    input wire logic [20:0] pad_pullup,
    input wire logic [20:0] ext_en,
    input wire logic [20:0] ext_val,
    output logic [20:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [20:0] float_q;
    // A floating pad shows a level that changes every cycle
    initial float_q = 21'h0AAAAA;
    always @(posedge clk_sys) begin
        float_q <= ~float_q;
    end
    // Device driver first, then board driver, then weak pullup
    always_comb begin
        for (int i = 0; i < 21; i++) begin
            if (pad_oe[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pad_pullup[i]) pad_in[i] = 1'b1;
            else pad_in[i] = float_q[i];
        end
    end
endmodule : pxb_board_model

// ### tb/pxb_port_io_crossbar_tb_top.sv
// Self-checking bench for the port I/O crossbar.
// Assumes the board model resolves the pads; no random stimulus.
module pxb_port_io_crossbar_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, reg_wr, reg_rd, port_match;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [18:0] periph_out, periph_oe, periph_in;
    logic [20:0] pad_in, pad_out, pad_oe, pad_pullup, ext_en, ext_val;
    logic [1:0] ext_int_level;
    logic [2:0] event_pulse;
    int mismatches = 0, num_checks = 0, cycles = 0, pulses;
    pxb_port_io_crossbar pxb_port_io_crossbar_inst (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .periph_out(periph_out), .periph_oe(periph_oe),
        .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_int_level(ext_int_level), .port_match(port_match),
        .event_pulse(event_pulse));
    pxb_board_model pxb_board_model_inst (.clk_sys(clk_sys), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pad_in));
    // Clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk8
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    // Reset state and register defaults
    task automatic t_reset();
        chk8(pad_oe[7:0] | pad_oe[15:8] | pad_oe[20:16], 8'h00, "reset oe");
        chk8(pad_pullup[7:0] & pad_pullup[15:8] & pad_pullup[20:13], 8'hFF, "reset pu");
        rd(pxb_pkg::ADDR_IN_MODE, rv);
        chk8(rv, 8'hFF, "in mode default");
        rd(8'h3A, rv);
        chk8(rv, 8'h00, "unmapped read");
    endtask : t_reset
    // Drivers off until crossbar enable, then GPIO from latch
    task automatic t_enable();
        wr(pxb_pkg::ADDR_LATCH, 8'h00);
        wr(pxb_pkg::ADDR_OUT_MODE, 8'hFF);
        wr(pxb_pkg::ADDR_OUT_MODE + 8'h02, 8'h10);
        settle();
        chk8(pad_oe[7:0], 8'h00, "disabled oe");
        chk8({7'h00, pad_oe[20]}, 8'h00, "disabled extra pin");
        wr(pxb_pkg::ADDR_SEL_HI, 8'h40);
        settle();
        chk8(pad_oe[7:0], 8'hFF, "enabled oe");
        chk8({6'h00, pad_oe[20], pad_out[20]}, 8'h03, "extra pin gpio");
        chk8(pad_out[7:0], 8'h00, "enabled out");
    endtask : t_enable
    // Push-pull, open-drain and pullup control
    task automatic t_modes();
        wr(pxb_pkg::ADDR_LATCH, 8'hAA);
        settle();
        chk8(pad_out[7:0] & pad_oe[7:0], 8'hAA, "push-pull");
        wr(pxb_pkg::ADDR_OUT_MODE, 8'h00);
        settle();
        chk8(pad_oe[7:0], 8'h55, "open-drain oe");
        chk8(pad_out[7:0] & pad_oe[7:0], 8'h00, "open-drain out");
        chk8(pad_pullup[7:0], 8'hAA, "pullup");
        wr(pxb_pkg::ADDR_SEL_HI, 8'hC0);
        settle();
        chk8(pad_pullup[7:0], 8'h00, "pullup disable");
        wr(pxb_pkg::ADDR_SEL_HI, 8'h40);
    endtask : t_modes
    // Readback of pad level and of analog pins
    task automatic t_read();
        wr(pxb_pkg::ADDR_LATCH, 8'hFF);
        ext_en[7:0] <= 8'hFF;
        ext_val[7:0] <= 8'h3C;
        settle();
        rd(pxb_pkg::ADDR_LATCH, rv);
        chk8(rv, 8'h3C, "digital read");
        ext_en[7:0] = 8'h00;
        wr(pxb_pkg::ADDR_IN_MODE, 8'h0F);
        wr(pxb_pkg::ADDR_OUT_MODE, 8'hFF);
        settle();
        chk8({pad_oe[7:4], pad_pullup[7:4]}, 8'h00, "analog cell");
        rd(pxb_pkg::ADDR_LATCH, rv);
        chk8(rv, 8'h0F, "analog read");
        wr(pxb_pkg::ADDR_IN_MODE, 8'hFF);
    endtask : t_read
    // Fixed serial pins, both claimed, skip ignored
    task automatic t_uart();
        wr(pxb_pkg::ADDR_SKIP, 8'h30);
        wr(pxb_pkg::ADDR_SEL_LO, 8'h01);
        @(posedge clk_sys);
        periph_oe <= 19'h00001;
        periph_out <= 19'h00000;
        ext_en[5] <= 1'b1;
        ext_val[5] <= 1'b0;
        settle();
        chk8({7'h00, pad_oe[4] & ~pad_out[4]}, 8'h01, "tx pin");
        chk8({7'h00, periph_in[1]}, 8'h00, "rx low");
        ext_val[5] = 1'b1;
        settle();
        chk8({7'h00, periph_in[1]}, 8'h01, "rx high");
        ext_en[5] = 1'b0;
    endtask : t_uart
    // Priority search with skipped pins and open-drain bus pins
    task automatic t_priority();
        wr(pxb_pkg::ADDR_SKIP, 8'h0C);
        wr(pxb_pkg::ADDR_SEL_LO, 8'h05);
        wr(pxb_pkg::ADDR_SEL_HI, 8'h41);
        @(posedge clk_sys);
        periph_oe <= 19'h02041;
        periph_out <= 19'h00041;
        settle();
        chk8({6'h00, pad_oe[6], pad_oe[0]}, 8'h02, "bus sda released");
        chk8({7'h00, pad_out[6]}, 8'h00, "channel pin");
        chk8({7'h00, pad_out[7] & pad_oe[7]}, 8'h01, "gpio after");
        @(posedge clk_sys);
        periph_out <= 19'h02000;
        settle();
        chk8({6'h00, pad_out[6], pad_oe[0] & ~pad_out[0]}, 8'h03, "sda low, ch high");
        wr(pxb_pkg::ADDR_SEL_LO, 8'h02);
        @(posedge clk_sys);
        periph_oe <= 19'h00024;
        periph_out <= 19'h00004;
        settle();
        chk8({3'h0, pad_oe[5], pad_out[5], pad_oe[4], pad_oe[0], pad_out[0]}, 8'h13, "spi pins");
        chk8({7'h00, periph_in[3]}, 8'h01, "spi input");
    endtask : t_priority
    // Port match and external interrupt on digital pins; no match on an analog pin
    task automatic t_events();
        wr(pxb_pkg::ADDR_SEL_LO, 8'h00);
        wr(pxb_pkg::ADDR_OUT_MODE, 8'h00);
        wr(pxb_pkg::ADDR_EXT_CFG, 8'h0A);
        wr(pxb_pkg::ADDR_P0_MASK, 8'h04);
        wr(pxb_pkg::ADDR_P0_VALUE, 8'h04);
        settle();
        chk8({5'h00, port_match, ext_int_level}, 8'h01, "idle events");
        pulses = 0;
        ext_en[2] = 1'b1;
        ext_val[2] = 1'b0;
        repeat (5) begin
            @(posedge clk_sys);
            #1 pulses += event_pulse[2];
        end
        chk8(pulses[7:0], 8'h01, "match pulse");
        chk8({5'h00, port_match, ext_int_level}, 8'h04, "match level");
        rd(pxb_pkg::ADDR_EVENT_STAT, rv);
        chk8(rv & 8'h04, 8'h04, "status");
        pulses = 0;
        ext_val[2] = 1'b1;
        repeat (5) begin
            @(posedge clk_sys);
            #1 pulses += event_pulse[0];
        end
        chk8(pulses[7:0], 8'h01, "int0 pulse");
        ext_val[2] = 1'b0;
        settle();
        wr(pxb_pkg::ADDR_IN_MODE, 8'hFB);
        settle();
        chk8({7'h00, port_match}, 8'h00, "analog no match");
    endtask : t_events
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        periph_out = 19'h00000;
        periph_oe = 19'h00000;
        ext_en = 21'h000000;
        ext_val = 21'h000000;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        settle();
        t_reset();
        t_enable();
        t_modes();
        t_read();
        t_uart();
        t_priority();
        t_events();
        complete_run();
    end
endmodule : pxb_port_io_crossbar_tb_top
